// >>> design/rwd_consts.svh
// Constants of the watchdog clock channel and its processor-side sequencer
`ifndef RWD_CONSTS_SVH
`define RWD_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define RWD_CLK_NS 8
`define RWD_RES_1US_NS 1000
`define RWD_RES_10US_NS 10000
`define RWD_RES_100US_NS 100000
`define RWD_RES_1MS_NS 1000000
`define RWD_CYC(ns) (((ns) + `RWD_CLK_NS - 1) / `RWD_CLK_NS)

// ----------------------------------------
// Device register map
// ----------------------------------------
`define RWD_IE_LOCAL 32'h96200020
`define RWD_IE_CPU0 32'h9D000020
`define RWD_IE_CPU1 32'h9D100020
`define RWD_IE_CPU2 32'h9D200020
`define RWD_IE_CPU3 32'h9D300020
`define RWD_CS_CPU0 32'hB2000000
`define RWD_CS_CPU1 32'hB2000008
`define RWD_CS_CPU2 32'hB6000000
`define RWD_CS_CPU3 32'hB6000008
`define RWD_CH_CTRL 32'h96300000
`define RWD_CH_COUNT 32'h96300004
`define RWD_CH_PEND 32'h96300008

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RWD_IE_CLK5_BIT 17
`define RWD_CS_ROUTE_BIT 11
`define RWD_CS_SOFT_RST_BIT 12
`define RWD_CS_FAULT_BIT 13
`define RWD_CTRL_RUN_BIT 0
`define RWD_CTRL_UP_BIT 1
`define RWD_CTRL_RELOAD_BIT 2
`define RWD_CTRL_ARM_BIT 3
`define RWD_CTRL_RES_LSB 4
`define RWD_IE_RESET 32'h00020000
`define RWD_CS_RESET 16'h0000
`define RWD_CTRL_RESET 8'h08
`define RWD_CTRL_WATCHDOG 32'h00000031
`define RWD_CTRL_ORDINARY 32'h00000008
`define RWD_TERM_UP 16'hFFFF
`define RWD_TERM_DOWN 16'h0000
`define RWD_SOFT_RST_VECTOR 32'h00000100

// ----------------------------------------
// Sequencer APB map and command codes
// ----------------------------------------
`define RWD_A_CMD 8'h00
`define RWD_A_ADDR 8'h04
`define RWD_A_WDATA 8'h08
`define RWD_A_RDATA 8'h0C
`define RWD_A_STATUS 8'h10
`define RWD_A_IRQ_STAT 8'h14
`define RWD_A_IRQ_MASK 8'h18
`define RWD_A_LOAD 8'h1C
`define RWD_A_SAVE 8'h20
`define RWD_A_VECTOR 8'h24
`define RWD_CMD_READ 3'h1
`define RWD_CMD_WRITE 3'h2
`define RWD_CMD_START 3'h3
`define RWD_CMD_STOP 3'h4
`define RWD_CMD_KICK 3'h5

`endif

// >>> design/rwd_counter.sv
// Sixteen-bit clock channel counter with selectable resolution
`timescale 1ns/1ns
`default_nettype none
`include "rwd_consts.svh"

module rwd_counter import rwd_pkg::*; #(
    parameter int CYC_1US = `RWD_CYC(`RWD_RES_1US_NS),
    parameter int CYC_10US = `RWD_CYC(`RWD_RES_10US_NS),
    parameter int CYC_100US = `RWD_CYC(`RWD_RES_100US_NS),
    parameter int CYC_1MS = `RWD_CYC(`RWD_RES_1MS_NS)
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic count_up,
    input wire logic auto_reload,
    input wire logic [1:0] res_sel,
    input wire logic load,
    input wire logic [15:0] load_value,
    output logic [15:0] count,
    output logic timeout
);

    rwd_cnt_st_t cnt_reg;
    rwd_cnt_st_t cnt_next;
    logic [15:0] stepped;
    logic [15:0] term;

    function automatic logic [19:0] res_limit(input logic [1:0] sel);
        case (sel)
            2'h0: res_limit = 20'(CYC_1US);
            2'h1: res_limit = 20'(CYC_10US);
            2'h2: res_limit = 20'(CYC_100US);
            default: res_limit = 20'(CYC_1MS);
        endcase
    endfunction

    assign stepped = count_up ? 16'(cnt_reg.count + 16'h0001) : 16'(cnt_reg.count - 16'h0001);
    assign term = count_up ? `RWD_TERM_UP : `RWD_TERM_DOWN; // RQ14

    always_comb begin
        cnt_next = cnt_reg;
        cnt_next.timeout = 1'b0;
        if (load) begin
            // Rewriting the count restarts the period, so no time-out follows
            cnt_next.count = load_value; // RQ15
            cnt_next.reload = load_value;
            cnt_next.prescale = 20'h00000;
            cnt_next.active = 1'b1;
        end else if (run && cnt_reg.active) begin
            if (cnt_reg.prescale >= 20'(res_limit(res_sel) - 20'h00001)) begin
                cnt_next.prescale = 20'h00000;
                cnt_next.count = stepped; // RQ14
                if (stepped == term) begin
                    cnt_next.timeout = 1'b1; // RQ15
                    if (auto_reload) begin
                        cnt_next.count = cnt_reg.reload; // RQ14
                    end else begin
                        cnt_next.active = 1'b0;
                    end
                end
            end else begin
                cnt_next.prescale = 20'(cnt_reg.prescale + 20'h00001);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg.count;
    assign timeout = cnt_reg.timeout;

endmodule

`default_nettype wire

// >>> design/rwd_cpu.sv
// Processor side: APB-driven watchdog setup sequencer and soft-reset handler
//
// Behaviour
// RQ1 - Only board-zero clock five acts as watchdog
// RQ2 - Time-out feeds interrupt logic and status register
// RQ3 - Software disarms the channel's interrupt level
// RQ4 - Routed time-out raises soft-reset request
// RQ5 - Request saves state, starts handler at vector
// RQ6 - Handler clears fault, then soft-reset bit
// RQ7 - Watchdog runs default mode, 1 ms per count
// RQ8 - Enable bit 17 masks clock interrupt
// RQ9 - Change bit 17 only, by read-modify-write
// RQ10 - Set bit 17 again when done
// RQ11 - Status bit 11 routes time-out, set by RMW
// RQ12 - Clear status bit 11 when done
// RQ13 - Program count and rate before use
// RQ14 - Counter counts to 0 or 65535, optional reload
// RQ15 - Terminal count gives one time-out; rewrite prevents
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "rwd_consts.svh"

module rwd_cpu import rwd_pkg::*; (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [31:0] save_restore_regs,
    rwd_if.cpu bus
);

    rwd_cpu_st_t cpu_reg;
    rwd_cpu_st_t cpu_next;
    logic wr_en;
    logic srst_rise;

    function automatic logic [31:0] apb_read(input rwd_cpu_st_t q, input logic [7:0] a);
        case (a)
            `RWD_A_ADDR: apb_read = q.raw_addr;
            `RWD_A_WDATA: apb_read = q.raw_wdata;
            `RWD_A_RDATA: apb_read = q.data;
            `RWD_A_STATUS: apb_read = {30'h00000000, q.hpend, q.state != ST_IDLE};
            `RWD_A_IRQ_STAT: apb_read = {29'h00000000, q.irq_stat};
            `RWD_A_IRQ_MASK: apb_read = {29'h00000000, q.irq_mask};
            `RWD_A_LOAD: apb_read = {16'h0000, q.load};
            `RWD_A_SAVE: apb_read = q.save;
            `RWD_A_VECTOR: apb_read = q.vector;
            default: apb_read = 32'h00000000;
        endcase
    endfunction

    assign wr_en = psel && penable && pwrite;
    // Same clock as the device, so no synchroniser is needed
    assign srst_rise = bus.soft_reset_request && !cpu_reg.srst_prev;

    always_comb begin
        logic [31:0] w;
        logic [2:0] cmd;
        logic done;
        w = 32'h00000000;
        cmd = 3'h0;
        done = 1'b0;
        cpu_next = cpu_reg;
        cpu_next.srst_prev = bus.soft_reset_request;

        // ----------------------------------------
        // APB slave
        // ----------------------------------------
        if (psel && !penable) begin
            cpu_next.prdata = apb_read(cpu_reg, paddr);
        end
        if (wr_en) begin
            case (paddr)
                `RWD_A_CMD: cmd = pwdata[2:0];
                `RWD_A_ADDR: cpu_next.raw_addr = pwdata;
                `RWD_A_WDATA: cpu_next.raw_wdata = pwdata;
                `RWD_A_IRQ_STAT: cpu_next.irq_stat = cpu_reg.irq_stat & ~pwdata[2:0];
                `RWD_A_IRQ_MASK: cpu_next.irq_mask = pwdata[2:0];
                `RWD_A_LOAD: cpu_next.load = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // ----------------------------------------
        // Soft-reset capture
        // ----------------------------------------
        if (srst_rise) begin
            cpu_next.save = cpu_reg.addr; // RQ5
            cpu_next.vector = `RWD_SOFT_RST_VECTOR; // RQ5
            cpu_next.hpend = 1'b1;
            cpu_next.irq_stat[1] = 1'b1;
        end

        // ----------------------------------------
        // Sequencer
        // ----------------------------------------
        case (cpu_reg.state)
            ST_IDLE: begin
                // A pending handler outranks a new command, which is then dropped
                if (cpu_reg.hpend || srst_rise) begin
                    cpu_next.hpend = 1'b0;
                    cpu_next.state = ST_H_RD; // RQ5
                end else if (cmd == `RWD_CMD_READ || cmd == `RWD_CMD_WRITE) begin
                    cpu_next.raw_we = (cmd == `RWD_CMD_WRITE);
                    cpu_next.state = ST_RAW;
                end else if (cmd == `RWD_CMD_START) begin
                    cpu_next.mode = MD_START;
                    cpu_next.state = ST_IE_RD; // RQ9
                end else if (cmd == `RWD_CMD_STOP) begin
                    cpu_next.mode = MD_STOP;
                    cpu_next.state = ST_CTL_WR;
                end else if (cmd == `RWD_CMD_KICK) begin
                    cpu_next.mode = MD_KICK;
                    cpu_next.state = ST_CNT_WR; // RQ15
                end
            end
            ST_RAW: begin
                if (bus.ack) begin
                    cpu_next.data = bus.rdata;
                    cpu_next.state = ST_IDLE;
                    done = 1'b1;
                end
            end
            ST_IE_RD: begin
                if (bus.ack) begin
                    cpu_next.data = bus.rdata; // RQ9
                    cpu_next.state = ST_IE_WR;
                end
            end
            ST_IE_WR: begin
                if (bus.ack) begin
                    cpu_next.state = ST_CS_RD;
                end
            end
            ST_CS_RD: begin
                if (bus.ack) begin
                    cpu_next.data = bus.rdata; // RQ11
                    cpu_next.state = ST_CS_WR;
                end
            end
            ST_CS_WR: begin
                if (bus.ack) begin
                    cpu_next.state = (cpu_reg.mode == MD_START) ? ST_CNT_WR : ST_IDLE;
                    done = (cpu_reg.mode != MD_START);
                end
            end
            ST_CNT_WR: begin
                if (bus.ack) begin
                    cpu_next.state = (cpu_reg.mode == MD_KICK) ? ST_IDLE : ST_CTL_WR;
                    done = (cpu_reg.mode == MD_KICK);
                end
            end
            ST_CTL_WR: begin
                if (bus.ack) begin
                    cpu_next.state = (cpu_reg.mode == MD_STOP) ? ST_IE_RD : ST_IDLE;
                    done = (cpu_reg.mode != MD_STOP);
                end
            end
            ST_H_RD: begin
                if (bus.ack) begin
                    cpu_next.data = bus.rdata;
                    // Without the fault flag the cause was not the watchdog
                    cpu_next.state = bus.rdata[`RWD_CS_FAULT_BIT] ? ST_H_FAULT_WR : ST_IDLE; // RQ6
                end
            end
            ST_H_FAULT_WR: begin
                if (bus.ack) begin
                    cpu_next.state = ST_H_SR_WR; // RQ6
                end
            end
            ST_H_SR_WR: begin
                if (bus.ack) begin
                    cpu_next.state = ST_IDLE;
                    cpu_next.irq_stat[2] = 1'b1;
                end
            end
            default: cpu_next.state = ST_IDLE;
        endcase
        if (done) begin
            cpu_next.irq_stat[0] = 1'b1;
        end

        // ----------------------------------------
        // Bus operation of the next state
        // ----------------------------------------
        w = cpu_next.data;
        cpu_next.we = 1'b1;
        case (cpu_next.state)
            ST_RAW: begin
                cpu_next.addr = cpu_next.raw_addr;
                cpu_next.we = cpu_next.raw_we;
                w = cpu_next.raw_wdata;
            end
            ST_IE_RD: begin
                cpu_next.addr = `RWD_IE_CPU0;
                cpu_next.we = 1'b0;
            end
            ST_IE_WR: begin
                cpu_next.addr = `RWD_IE_CPU0;
                // Cleared while watching, set again on stop
                w[`RWD_IE_CLK5_BIT] = (cpu_next.mode != MD_START); // RQ8 RQ9 RQ10
            end
            ST_CS_RD: begin
                cpu_next.addr = `RWD_CS_CPU0;
                cpu_next.we = 1'b0;
            end
            ST_CS_WR: begin
                cpu_next.addr = `RWD_CS_CPU0;
                w[`RWD_CS_ROUTE_BIT] = (cpu_next.mode == MD_START); // RQ11 RQ12
            end
            ST_CNT_WR: begin
                cpu_next.addr = `RWD_CH_COUNT;
                w = {16'h0000, cpu_next.load}; // RQ13
            end
            ST_CTL_WR: begin
                cpu_next.addr = `RWD_CH_CTRL;
                // Watchdog: down count, 1 ms, no reload, interrupt level disarmed
                w = (cpu_next.mode == MD_STOP) ? `RWD_CTRL_ORDINARY : `RWD_CTRL_WATCHDOG; // RQ3 RQ7 RQ13
            end
            ST_H_RD: begin
                cpu_next.addr = `RWD_CS_CPU0;
                cpu_next.we = 1'b0;
            end
            ST_H_FAULT_WR: begin
                cpu_next.addr = `RWD_CS_CPU0;
                w[`RWD_CS_FAULT_BIT] = 1'b0; // RQ6
            end
            ST_H_SR_WR: begin
                cpu_next.addr = `RWD_CS_CPU0;
                w[`RWD_CS_FAULT_BIT] = 1'b0;
                w[`RWD_CS_SOFT_RST_BIT] = 1'b0; // RQ6
            end
            default: cpu_next.we = 1'b0;
        endcase
        cpu_next.wdata = w;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpu_reg <= '0;
        end else begin
            cpu_reg <= cpu_next;
        end
    end

    assign prdata = cpu_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign irq = |(cpu_reg.irq_stat & cpu_reg.irq_mask);
    assign save_restore_regs = cpu_reg.save;
    assign bus.req = (cpu_reg.state != ST_IDLE);
    assign bus.we = cpu_reg.we;
    assign bus.addr = cpu_reg.addr;
    assign bus.wdata = cpu_reg.wdata;

endmodule

`default_nettype wire

// >>> design/rwd_device.sv
// Board clock channel five with interrupt enables and processor status registers
`timescale 1ns/1ns
`default_nettype none
`include "rwd_consts.svh"

module rwd_device import rwd_pkg::*; #(
    parameter int CYC_100US = `RWD_CYC(`RWD_RES_100US_NS),
    parameter int CYC_1MS = `RWD_CYC(`RWD_RES_1MS_NS)
) (
    input wire logic core_clk,
    input wire logic reset,
    rwd_if.dev bus,
    output logic clk_irq,
    output logic timeout,
    output logic [15:0] count_value
);

    rwd_dev_st_t dev_reg;
    rwd_dev_st_t dev_next;
    logic take;
    logic load;
    logic tmo;

    function automatic logic [31:0] ie_addr(input int i);
        case (i)
            0: ie_addr = `RWD_IE_CPU0;
            1: ie_addr = `RWD_IE_CPU1;
            2: ie_addr = `RWD_IE_CPU2;
            default: ie_addr = `RWD_IE_CPU3;
        endcase
    endfunction

    function automatic logic [31:0] cs_addr(input int i);
        case (i)
            0: cs_addr = `RWD_CS_CPU0;
            1: cs_addr = `RWD_CS_CPU1;
            2: cs_addr = `RWD_CS_CPU2;
            default: cs_addr = `RWD_CS_CPU3;
        endcase
    endfunction

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    assign take = bus.req && !dev_reg.ack;
    assign load = take && bus.we && (bus.addr == `RWD_CH_COUNT);

    always_comb begin
        dev_next = dev_reg;
        dev_next.ack = take;
        if (take) begin
            dev_next.rdata = 32'h00000000;
            for (int i = 0; i < 4; i++) begin
                // Local alias serves the first processor, the one this board talks to
                if (bus.addr == ie_addr(i) || (i == 0 && bus.addr == `RWD_IE_LOCAL)) begin
                    dev_next.rdata = dev_reg.ie[i];
                    if (bus.we) begin
                        dev_next.ie[i] = bus.wdata; // RQ8
                    end
                end
                if (bus.addr == cs_addr(i)) begin
                    dev_next.rdata = {16'h0000, dev_reg.cs[i]};
                    if (bus.we) begin
                        dev_next.cs[i] = bus.wdata[15:0]; // RQ11
                    end
                end
            end
            case (bus.addr)
                `RWD_CH_CTRL: begin
                    dev_next.rdata = {24'h000000, dev_reg.ctrl};
                    if (bus.we) begin
                        dev_next.ctrl = bus.wdata[7:0];
                    end
                end
                `RWD_CH_COUNT: dev_next.rdata = {16'h0000, count_value};
                `RWD_CH_PEND: begin
                    dev_next.rdata = dev_reg.pend;
                    if (bus.we) begin
                        dev_next.pend = dev_reg.pend & ~bus.wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        // Time-out effects come after the writes so that a set beats a clear
        if (tmo) begin
            if (dev_reg.ctrl[`RWD_CTRL_ARM_BIT]) begin
                dev_next.pend[`RWD_IE_CLK5_BIT] = 1'b1; // RQ2
            end
            // Only the first processor's status register carries the route
            if (dev_reg.cs[0][`RWD_CS_ROUTE_BIT]) begin // RQ1
                dev_next.cs[0][`RWD_CS_SOFT_RST_BIT] = 1'b1; // RQ4
                dev_next.cs[0][`RWD_CS_FAULT_BIT] = 1'b1; // RQ2
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dev_reg <= '0;
            dev_reg.ie <= {4{`RWD_IE_RESET}};
            dev_reg.cs <= {4{`RWD_CS_RESET}};
            dev_reg.ctrl <= `RWD_CTRL_RESET;
        end else begin
            dev_reg <= dev_next;
        end
    end

    // ----------------------------------------
    // Clock channel five
    // ----------------------------------------
    rwd_counter #(
        .CYC_100US(CYC_100US),
        .CYC_1MS(CYC_1MS)
    ) u_counter (
        .core_clk(core_clk),
        .reset(reset),
        .run(dev_reg.ctrl[`RWD_CTRL_RUN_BIT]),
        .count_up(dev_reg.ctrl[`RWD_CTRL_UP_BIT]),
        .auto_reload(dev_reg.ctrl[`RWD_CTRL_RELOAD_BIT]),
        .res_sel(dev_reg.ctrl[`RWD_CTRL_RES_LSB +: 2]),
        .load(load),
        .load_value(bus.wdata[15:0]),
        .count(count_value),
        .timeout(tmo)
    );

    // Mask at the interrupt controller only gates the ordinary interrupt
    assign clk_irq = |(dev_reg.pend & dev_reg.ie[0]); // RQ8
    assign timeout = tmo;
    assign bus.ack = dev_reg.ack;
    assign bus.rdata = dev_reg.rdata;
    assign bus.soft_reset_request = dev_reg.cs[0][`RWD_CS_SOFT_RST_BIT]; // RQ4

endmodule

`default_nettype wire

// >>> design/rwd_if.sv
// Register access and soft-reset link between processor and watchdog channel
`timescale 1ns/1ns
`default_nettype none

interface rwd_if;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic soft_reset_request;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output ack,
        output soft_reset_request
    );

    modport cpu (
        output req,
        output we,
        output addr,
        output wdata,
        input rdata,
        input ack,
        input soft_reset_request
    );
endinterface

`default_nettype wire

// >>> design/rwd_pkg.sv
// Types shared by the watchdog channel and its processor-side sequencer
package rwd_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RAW, ST_IE_RD, ST_IE_WR, ST_CS_RD, ST_CS_WR,
        ST_CNT_WR, ST_CTL_WR, ST_H_RD, ST_H_FAULT_WR, ST_H_SR_WR
    } rwd_state_t;

    typedef enum logic [1:0] {MD_START, MD_STOP, MD_KICK} rwd_mode_t;

    typedef struct packed {
        logic [19:0] prescale;
        logic [15:0] count;
        logic [15:0] reload;
        logic active;
        logic timeout;
    } rwd_cnt_st_t;

    typedef struct packed {
        logic [3:0][31:0] ie;
        logic [3:0][15:0] cs;
        logic [7:0] ctrl;
        logic [31:0] pend;
        logic ack;
        logic [31:0] rdata;
    } rwd_dev_st_t;

    typedef struct packed {
        rwd_state_t state;
        rwd_mode_t mode;
        logic raw_we;
        logic [31:0] raw_addr;
        logic [31:0] raw_wdata;
        logic [31:0] addr;
        logic we;
        logic [31:0] wdata;
        logic [31:0] data;
        logic [15:0] load;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] save;
        logic [31:0] vector;
        logic srst_prev;
        logic hpend;
        logic [31:0] prdata;
    } rwd_cpu_st_t;

endpackage

// >>> verification/rtc_watchdog_soft_reset_tb.sv
// Bench joining both ends of the watchdog link
`timescale 1ns/1ns
`default_nettype none
module rtc_watchdog_soft_reset_tb;
    // ----------------
    // Harness
    // ----------------
    logic core_clk = 0;
    logic reset = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata, save_regs, r, v;
    logic pready, pslverr, irq, clk_irq, timeout;
    logic [15:0] count_value;
    int fails = 0;
    int checked = 0;
    int tos = 0;
    rwd_if link();
    // Short prescalers keep a 1 ms tick at 20 cycles
    rwd_device #(.CYC_100US(10), .CYC_1MS(20)) i_rwd_device(.core_clk(core_clk), .reset(reset), .bus(link.dev),
        .clk_irq(clk_irq), .timeout(timeout), .count_value(count_value));
    rwd_cpu i_rwd_cpu(.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .save_restore_regs(save_regs), .bus(link.cpu));
    rwd_sva i_chk(.core_clk(core_clk), .reset(reset), .req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .soft_reset_request(link.soft_reset_request));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (timeout === 1'h1) tos <= tos + 1;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: %h not %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        r = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic cmd(input logic [31:0] c);
        apb(1'h1, 8'h00, c);
        do apb(1'h0, 8'h10, 32'h0); while (r[0] !== 1'h0);
    endtask
    task automatic dev(input logic w, input logic [31:0] a, input logic [31:0] d);
        apb(1'h1, 8'h04, a);
        apb(1'h1, 8'h08, d);
        cmd(w ? 32'h2 : 32'h1);
        apb(1'h0, 8'h0C, 32'h0);
    endtask
    function automatic logic [31:0] with_bit(input logic [31:0] b, input int n, input logic x);
        with_bit = b;
        with_bit[n] = x;
    endfunction
    task automatic irq_is(input logic [31:0] m, input logic e);
        apb(1'h1, 8'h18, m);
        @(negedge core_clk);
        chk(irq, e);
    endtask
    initial begin
        void'($urandom(32'hFE87));
        repeat (5) @(posedge core_clk);
        reset <= 1'h0;
        dev(1'h0, 32'h9D000020, 32'h0);
        chk(r, 32'h00020000);
        v = $urandom;
        dev(1'h1, 32'h9D100020, v);
        dev(1'h0, 32'h9D100020, 32'h0);
        chk(r, v);
        dev(1'h0, 32'h00000040, 32'h0);
        chk(r, 32'h0);
        // Random neighbours of bit 17 must survive the masking
        v = $urandom | 32'h00020000;
        dev(1'h1, 32'h9D000020, v);
        apb(1'h1, 8'h18, 32'h7);
        apb(1'h1, 8'h1C, $urandom_range(6, 9));
        cmd(32'h3);
        dev(1'h0, 32'h9D000020, 32'h0);
        chk(r, with_bit(v, 17, 1'h0));
        dev(1'h0, 32'hB2000000, 32'h0);
        chk(r, with_bit(32'h0, 11, 1'h1));
        dev(1'h0, 32'h96300000, 32'h0);
        chk(r, 32'h00000031);
        do apb(1'h0, 8'h14, 32'h0); while (r[2] !== 1'h1);
        chk(r, 32'h7);
        apb(1'h0, 8'h24, 32'h0);
        chk(r, 32'h00000100);
        chk({pslverr, irq, clk_irq, link.soft_reset_request}, 32'h4);
        chk(save_regs, 32'h96300000);
        chk(count_value, 32'h0);
        chk(tos, 32'h1);
        dev(1'h0, 32'hB2000000, 32'h0);
        chk(r, with_bit(32'h0, 11, 1'h1));
        irq_is(32'h0, 1'h0);
        irq_is(32'h4, 1'h1);
        apb(1'h1, 8'h14, 32'h7);
        irq_is(32'h4, 1'h0);
        cmd(32'h4);
        dev(1'h0, 32'h9D000020, 32'h0);
        chk(r, v);
        dev(1'h0, 32'hB2000000, 32'h0);
        chk(r, 32'h0);
        // Kicks spaced below the 4-tick period must hold off the time-out
        apb(1'h1, 8'h1C, 32'h4);
        cmd(32'h3);
        repeat (4) begin
            repeat (30) @(posedge core_clk);
            cmd(32'h5);
        end
        cmd(32'h4);
        repeat (200) @(posedge core_clk);
        chk(tos, 32'h1);
        chk({clk_irq, link.soft_reset_request}, 32'h0);
        // Ordinary use: armed, 100 us ticks, unrouted, so only the interrupt fires
        dev(1'h1, 32'h96300004, 32'h2);
        dev(1'h1, 32'h96300000, 32'h29);
        repeat (60) @(posedge core_clk);
        chk({clk_irq, link.soft_reset_request}, 32'h2);
        chk(tos, 32'h2);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        conclude();
    end
endmodule
`default_nettype wire

// >>> verification/rwd_sva.sv
// Checker of the processor-to-channel link
`timescale 1ns/1ns
`default_nettype none
module rwd_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic soft_reset_request
);
    // ----------------
    // Shadow of writes
    // ----------------
    logic take;
    logic cs_wr;
    logic route_reg;
    logic [31:0] ie_reg;
    assign take = req && !ack;
    assign cs_wr = take && we && addr == 32'hB2000000;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            route_reg <= 1'h0;
            ie_reg <= 32'h00020000;
        end else begin
            if (cs_wr) begin
                route_reg <= wdata[11];
            end
            if (take && we && (addr == 32'h9D000020 || addr == 32'h96200020)) begin
                ie_reg <= wdata;
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    ack_one_cycle_a: assert property (ack |=> !ack) else $error("ack too long");
    ack_on_take_a: assert property (take |=> ack) else $error("no ack");
    ie_readback_a: assert property (take && !we && addr == 32'h9D000020 |=> rdata == ie_reg)
        else $error("enable readback");
    cs_upper_zero_a: assert property (take && !we && addr == 32'hB2000000 |=> rdata[31:16] == 16'h0000)
        else $error("status upper bits");
    unmapped_zero_a: assert property (take && !we && addr[31:28] == 4'h0 |=> rdata == 32'h0)
        else $error("unmapped read");
    reset_routed_a: assert property ($rose(soft_reset_request) |-> route_reg) else $error("unrouted reset");
    reset_holds_a: assert property (soft_reset_request && !cs_wr && !$past(cs_wr) |=> soft_reset_request)
        else $error("reset dropped");
    reset_cleared_a: assert property (cs_wr && !wdata[12] |-> ##2 !soft_reset_request)
        else $error("reset not cleared");
endmodule
`default_nettype wire
